//--- hw/spt_tx_port.sv
// Secondary audio serial port: configuration registers and data transmitter.
// Assumes APB on ref_clk; bit clock and frame sync pins are asynchronous.
`timescale 1ns/100ps

module spt_tx_port #(
   parameter int NUM_PINS = 2,
   parameter int INT_BCLK_HALF = 4
) (
   input wire logic refClk, // 40 MHz system clock
   input wire logic srst, // Synchronous reset, active high
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic bitClockIn, // External bit clock pin
   input wire logic frameSyncIn, // External frame sync pin
   output logic bitClockOut, // Internal bit clock drive
   output logic frameSyncOut, // Internal frame sync drive
   input wire logic [31:0] txWord [NUM_PINS], // Word per data pin
   output logic txWordTaken, // Pulse: words latched
   output logic [NUM_PINS-1:0] dataOut, // Data pin levels
   output logic [NUM_PINS-1:0] dataOe, // Data pin enables
   output logic keeperOn, // Data pin bus keeper enable
   output logic irq // Level interrupt
);
   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   logic [7:0] page_reg, page_next;
   logic [7:0] fmtCfg_reg, fmtCfg_next;
   logic [7:0] drvCfg_reg, drvCfg_next;
   logic [4:0] offset_reg, offset_next;
   logic [1:0] irqEn_reg, irqEn_next;
   logic [1:0] irqSt_reg, irqSt_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic irq_reg, irq_next;
   logic [1:0] events;
   logic [7:0] idx;
   logic onPage, mapped, wrDone, fmtWritten;
   spt_pkg::spt_state_t state_reg, state_next;

   assign idx = paddr[9:2];
   assign onPage = (page_reg == spt_pkg::PORT_PAGE);
   assign wrDone = psel && penable && pready_reg && pwrite && !pslverr_reg;
   assign fmtWritten = wrDone && (idx == spt_pkg::IDX_FORMAT_CFG);

   // Decode, read mux, write effects and sticky status
   always_comb begin
      page_next = page_reg;
      fmtCfg_next = fmtCfg_reg;
      drvCfg_next = drvCfg_reg;
      offset_next = offset_reg;
      irqEn_next = irqEn_reg;
      prdata_next = prdata_reg;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      mapped = 1'b1;
      irqSt_next = irqSt_reg;
      if (psel && !penable) begin
         pready_next = 1'b1;
         prdata_next = 32'h0;
         if (idx == spt_pkg::IDX_PAGE_SELECT) begin
            prdata_next[7:0] = page_reg;
         end else if (!onPage) begin
            mapped = 1'b0;
         end else if (idx == spt_pkg::IDX_FORMAT_CFG) begin
            prdata_next[7:0] = fmtCfg_reg;
         end else if (idx == spt_pkg::IDX_TX_DRIVE_CFG) begin
            prdata_next[7:0] = drvCfg_reg;
         end else if (idx == spt_pkg::IDX_TX_OFFSET_CFG) begin
            prdata_next[4:0] = offset_reg;
         end else if (idx == spt_pkg::IDX_IRQ_STATUS) begin
            prdata_next[1:0] = irqSt_reg;
         end else if (idx == spt_pkg::IDX_IRQ_CLEAR) begin
            prdata_next = 32'h0;
         end else if (idx == spt_pkg::IDX_IRQ_ENABLE) begin
            prdata_next[1:0] = irqEn_reg;
         end else if (idx == spt_pkg::IDX_PORT_STATE) begin
            prdata_next[1:0] = state_reg;
         end else begin
            mapped = 1'b0;
         end
         pslverr_next = !mapped || (paddr[1:0] != 2'h0);
         if (pslverr_next) prdata_next = 32'h0; // Refused access reads zero
      end
      if (wrDone) begin
         if (idx == spt_pkg::IDX_PAGE_SELECT) begin
            page_next = pwdata[7:0];
         end else if (idx == spt_pkg::IDX_FORMAT_CFG) begin
            fmtCfg_next = pwdata[7:0];
         end else if (idx == spt_pkg::IDX_TX_DRIVE_CFG) begin
            drvCfg_next = pwdata[7:0];
         end else if (idx == spt_pkg::IDX_TX_OFFSET_CFG) begin
            offset_next = pwdata[4:0];
         end else if (idx == spt_pkg::IDX_IRQ_CLEAR) begin
            irqSt_next = irqSt_reg & ~pwdata[1:0];
         end else if (idx == spt_pkg::IDX_IRQ_ENABLE) begin
            irqEn_next = pwdata[1:0];
         end
      end
      irqSt_next = irqSt_next | events; // Set wins over clear
      irq_next = |(irqSt_next & irqEn_next);
   end

   // Register file state
   always_ff @(posedge refClk) begin
      if (srst) begin
         page_reg <= spt_pkg::RST_PAGE_SELECT;
         fmtCfg_reg <= spt_pkg::RST_FORMAT_CFG;
         drvCfg_reg <= spt_pkg::RST_TX_DRIVE_CFG;
         offset_reg <= spt_pkg::RST_TX_OFFSET;
         irqEn_reg <= 2'h0;
         irqSt_reg <= 2'h0;
         prdata_reg <= 32'h0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         page_reg <= page_next;
         fmtCfg_reg <= fmtCfg_next;
         drvCfg_reg <= drvCfg_next;
         offset_reg <= offset_next;
         irqEn_reg <= irqEn_next;
         irqSt_reg <= irqSt_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         irq_reg <= irq_next;
      end
   end

   // ------------------------------------------------------------
   // Configuration fields
   // ------------------------------------------------------------
   spt_pkg::spt_format_t fmt;
   spt_pkg::spt_keeper_t keepMode;
   logic [5:0] wlen, delay;
   assign fmt = spt_pkg::spt_format_t'(fmtCfg_reg[spt_pkg::FMT_LSB +: 2]);
   assign keepMode = spt_pkg::spt_keeper_t'(drvCfg_reg[spt_pkg::KEEPER_LSB +: 2]);

   // Word length decode and slot zero MSB position
   always_comb begin
      case (fmtCfg_reg[spt_pkg::WLEN_LSB +: 2])
         2'h0: wlen = spt_pkg::WLEN_16;
         2'h1: wlen = spt_pkg::WLEN_20;
         2'h2: wlen = spt_pkg::WLEN_24;
         default: wlen = spt_pkg::WLEN_32;
      endcase
      delay = {1'b0, offset_reg};
      if (fmt == spt_pkg::FMT_I2S) begin
         delay = delay + spt_pkg::I2S_DELAY;
      end
   end

   // ------------------------------------------------------------
   // Internal bit clock and frame sync generator
   // ------------------------------------------------------------
   logic [15:0] div_reg, div_next;
   logic intBclk_reg, intBclk_next;
   logic [6:0] intCnt_reg, intCnt_next;
   logic intFs_reg, intFs_next;
   logic [6:0] pulseW;

   // Divider, frame counter and standard-polarity frame sync
   always_comb begin
      div_next = div_reg + 16'h1;
      intBclk_next = intBclk_reg;
      intCnt_next = intCnt_reg;
      pulseW = drvCfg_reg[spt_pkg::TDM_PW_BIT] ? 7'h2 : 7'h1;
      if (div_reg == 16'(INT_BCLK_HALF - 1)) begin
         div_next = 16'h0;
         intBclk_next = !intBclk_reg;
         if (intBclk_reg) begin
            intCnt_next = (intCnt_reg >= {wlen, 1'b0} - 7'h1) ? 7'h0 : intCnt_reg + 7'h1;
         end
      end
      case (fmt)
         spt_pkg::FMT_TDM: intFs_next = intCnt_next < pulseW;
         spt_pkg::FMT_I2S: intFs_next = intCnt_next >= {1'b0, wlen};
         default: intFs_next = intCnt_next < {1'b0, wlen};
      endcase
   end

   // Generator state
   always_ff @(posedge refClk) begin
      if (srst) begin
         div_reg <= 16'h0;
         intBclk_reg <= 1'b0;
         intCnt_reg <= 7'h0;
         intFs_reg <= 1'b0;
         bitClockOut <= 1'b0;
         frameSyncOut <= 1'b0;
      end else begin
         div_reg <= div_next;
         intBclk_reg <= intBclk_next;
         intCnt_reg <= intCnt_next;
         intFs_reg <= intFs_next;
         bitClockOut <= intBclk_reg ^ fmtCfg_reg[spt_pkg::BCLK_INV_BIT];
         frameSyncOut <= intFs_reg ^ fmtCfg_reg[spt_pkg::FS_INV_BIT];
      end
   end

   // ------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ------------------------------------------------------------
   logic [1:0] bclkSync_reg, fsSync_reg;
   logic bclkPrev_reg, fsPrev_reg;
   logic bclkLvl, fsLvl, riseEvt, fallEvt, launchEvt, midEvt, fsEdge, halfStart;

   // Two-stage capture of the link pins
   always_ff @(posedge refClk) begin
      if (srst) begin
         bclkSync_reg <= 2'h0;
         fsSync_reg <= 2'h0;
         bclkPrev_reg <= 1'b0;
         fsPrev_reg <= 1'b0;
      end else begin
         bclkSync_reg <= {bclkSync_reg[0], bitClockIn};
         fsSync_reg <= {fsSync_reg[0], frameSyncIn};
         bclkPrev_reg <= bclkLvl;
         fsPrev_reg <= riseEvt ? fsLvl : fsPrev_reg; // Frame sync level at last rise
      end
   end

   // Protocol-polarity levels and edge events
   always_comb begin
      bclkLvl = drvCfg_reg[spt_pkg::INT_BCLK_BIT] ? intBclk_reg :
         (bclkSync_reg[1] ^ fmtCfg_reg[spt_pkg::BCLK_INV_BIT]);
      fsLvl = drvCfg_reg[spt_pkg::INT_FS_BIT] ? intFs_reg :
         (fsSync_reg[1] ^ fmtCfg_reg[spt_pkg::FS_INV_BIT]);
      riseEvt = bclkLvl && !bclkPrev_reg;
      fallEvt = !bclkLvl && bclkPrev_reg;
      launchEvt = drvCfg_reg[spt_pkg::EDGE_SEL_BIT] ? riseEvt : fallEvt;
      midEvt = drvCfg_reg[spt_pkg::EDGE_SEL_BIT] ? fallEvt : riseEvt;
      fsEdge = (fmt == spt_pkg::FMT_TDM) ? (fsLvl && !fsPrev_reg) : (fsLvl != fsPrev_reg);
      halfStart = riseEvt && fsEdge;
   end

   // ------------------------------------------------------------
   // Transmit sequencer
   // ------------------------------------------------------------
   logic [6:0] bitCnt_reg, bitCnt_next;
   logic seen_reg, seen_next;
   logic lsb_reg, lsb_next, tail_reg, tail_next;
   logic taken_reg, taken_next, keep_next;
   logic [31:0] word_reg [NUM_PINS];
   logic [NUM_PINS-1:0] dout_next, doe_next;
   logic active, isLsb, shortHalf, busErr;
   logic [6:0] pos;
   logic [4:0] bitIdx;

   // Slot position, run state and error detection
   always_comb begin
      pos = bitCnt_reg - {1'b0, delay};
      active = (bitCnt_reg >= {1'b0, delay}) && (pos < {1'b0, wlen});
      isLsb = active && (pos == {1'b0, wlen} - 7'h1);
      bitIdx = 5'(wlen - 6'h1 - pos[5:0]);
      shortHalf = seen_reg && (bitCnt_reg < {1'b0, wlen} + {1'b0, delay});
      busErr = halfStart && shortHalf && !fmtCfg_reg[spt_pkg::ERR_DET_OFF_BIT]
         && (state_reg == spt_pkg::ST_RUN);
      state_next = state_reg;
      case (state_reg)
         spt_pkg::ST_IDLE: begin
            if (fmt != spt_pkg::FMT_RESERVED) state_next = spt_pkg::ST_RUN;
         end
         spt_pkg::ST_RUN: begin
            if (fmt == spt_pkg::FMT_RESERVED) begin
               state_next = spt_pkg::ST_IDLE;
            end else if (busErr) begin
               state_next = fmtCfg_reg[spt_pkg::RESUME_OFF_BIT] ?
                  spt_pkg::ST_HALT : spt_pkg::ST_RECOVER;
            end
         end
         spt_pkg::ST_RECOVER: begin
            if (halfStart) state_next = spt_pkg::ST_RUN;
         end
         spt_pkg::ST_HALT: begin
            if (fmtWritten) state_next = spt_pkg::ST_IDLE;
         end
         default: state_next = spt_pkg::ST_IDLE;
      endcase
      events = 2'h0;
      events[spt_pkg::IRQ_BUS_ERR] = busErr;
      events[spt_pkg::IRQ_HALF_START] = halfStart && (state_reg == spt_pkg::ST_RUN);
   end

   // Bit counter, LSB tracking and keeper
   always_comb begin
      bitCnt_next = bitCnt_reg;
      seen_next = seen_reg;
      lsb_next = lsb_reg;
      tail_next = tail_reg;
      taken_next = halfStart;
      if (halfStart) begin
         bitCnt_next = 7'h0;
         seen_next = (state_reg == spt_pkg::ST_RUN);
      end else if (launchEvt) begin
         if (bitCnt_reg != spt_pkg::CNT_MAX) bitCnt_next = bitCnt_reg + 7'h1;
         lsb_next = isLsb && (state_reg == spt_pkg::ST_RUN);
         tail_next = lsb_reg;
      end else if (midEvt) begin
         tail_next = 1'b0;
      end
      case (keepMode)
         spt_pkg::KEEP_OFF: keep_next = 1'b0;
         spt_pkg::KEEP_ON: keep_next = 1'b1;
         spt_pkg::KEEP_LSB_ONE: keep_next = lsb_next;
         default: keep_next = lsb_next || tail_next;
      endcase
   end

   // Sequencer state
   always_ff @(posedge refClk) begin
      if (srst) begin
         state_reg <= spt_pkg::ST_IDLE;
         bitCnt_reg <= spt_pkg::CNT_MAX;
         seen_reg <= 1'b0;
         lsb_reg <= 1'b0;
         tail_reg <= 1'b0;
         taken_reg <= 1'b0;
         keeperOn <= 1'b0;
      end else begin
         state_reg <= state_next;
         bitCnt_reg <= bitCnt_next;
         seen_reg <= seen_next;
         lsb_reg <= lsb_next;
         tail_reg <= tail_next;
         taken_reg <= taken_next;
         keeperOn <= keep_next;
      end
   end

   // Per-pin word latch and drive
   for (genvar i = 0; i < NUM_PINS; i++) begin : gPin
      always_comb begin
         dout_next[i] = dataOut[i];
         doe_next[i] = dataOe[i];
         if (state_reg != spt_pkg::ST_RUN) begin
            dout_next[i] = 1'b0;
            doe_next[i] = 1'b0;
         end else if (launchEvt && !halfStart) begin
            if (active) begin
               dout_next[i] = word_reg[i][bitIdx];
               doe_next[i] = 1'b1;
            end else begin
               dout_next[i] = 1'b0;
               doe_next[i] = !drvCfg_reg[spt_pkg::FILL_HIZ_BIT];
            end
         end else if (midEvt && lsb_reg && drvCfg_reg[spt_pkg::LSB_HALF_BIT]) begin
            doe_next[i] = 1'b0;
         end
      end

      always_ff @(posedge refClk) begin
         if (srst) begin
            word_reg[i] <= 32'h0;
            dataOut[i] <= 1'b0;
            dataOe[i] <= 1'b0;
         end else begin
            if (halfStart) word_reg[i] <= txWord[i];
            dataOut[i] <= dout_next[i];
            dataOe[i] <= doe_next[i];
         end
      end
   end

   // Bus outputs
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq = irq_reg;
   assign txWordTaken = taken_reg;
endmodule : spt_tx_port

//--- hw/spt_pkg.sv
// Constants shared by the secondary serial port transmit block.
// Assumes an APB register bus with 32-bit data and word-aligned registers.
package spt_pkg;
   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_PAGE_SELECT = 8'h00;
   localparam logic [7:0] IDX_FORMAT_CFG = 8'h1a;
   localparam logic [7:0] IDX_TX_DRIVE_CFG = 8'h1b;
   localparam logic [7:0] IDX_TX_OFFSET_CFG = 8'h1c;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
   localparam logic [7:0] IDX_IRQ_CLEAR = 8'h31;
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'h32;
   localparam logic [7:0] IDX_PORT_STATE = 8'h33;
   localparam logic [7:0] PORT_PAGE = 8'h00;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_PAGE_SELECT = 8'h00;
   localparam logic [7:0] RST_FORMAT_CFG = 8'h30;
   localparam logic [7:0] RST_TX_DRIVE_CFG = 8'h00;
   localparam logic [4:0] RST_TX_OFFSET = 5'h00;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int FMT_LSB = 6;
   localparam int WLEN_LSB = 4;
   localparam int FS_INV_BIT = 3;
   localparam int BCLK_INV_BIT = 2;
   localparam int ERR_DET_OFF_BIT = 1;
   localparam int RESUME_OFF_BIT = 0;
   localparam int EDGE_SEL_BIT = 7;
   localparam int FILL_HIZ_BIT = 6;
   localparam int LSB_HALF_BIT = 5;
   localparam int KEEPER_LSB = 3;
   localparam int INT_FS_BIT = 2;
   localparam int INT_BCLK_BIT = 1;
   localparam int TDM_PW_BIT = 0;
   localparam int OFFSET_W = 5;
   localparam int IRQ_W = 2;
   localparam int IRQ_BUS_ERR = 0;
   localparam int IRQ_HALF_START = 1;

   // ------------------------------------------------------------
   // Encodings
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      FMT_TDM = 2'h0, FMT_I2S = 2'h1, FMT_LEFT_JUSTIFIED = 2'h2, FMT_RESERVED = 2'h3
   } spt_format_t;
   typedef enum logic [1:0] {
      KEEP_OFF = 2'h0, KEEP_ON = 2'h1, KEEP_LSB_ONE = 2'h2, KEEP_LSB_ONE_HALF = 2'h3
   } spt_keeper_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0, ST_RUN = 2'h1, ST_RECOVER = 2'h2, ST_HALT = 2'h3
   } spt_state_t;
   localparam logic [5:0] WLEN_16 = 6'h10;
   localparam logic [5:0] WLEN_20 = 6'h14;
   localparam logic [5:0] WLEN_24 = 6'h18;
   localparam logic [5:0] WLEN_32 = 6'h20;
   localparam logic [5:0] I2S_DELAY = 6'h01;
   localparam logic [6:0] CNT_MAX = 7'h7f;
endpackage : spt_pkg

//--- verification/spt_tx_monitor.sv
// Port checker for spt_tx_port: register bus answers and pin behaviour.
// Assumes it is bound to every spt_tx_port instance.
`timescale 1ns/100ps
module spt_tx_monitor #(
   parameter int INT_BCLK_HALF = 4
) (
   input wire logic refClk, // System clock
   input wire logic srst, // Reset
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [31:0] prdata, // APB read data
   input wire logic pready, // APB ready
   input wire logic pslverr, // APB error
   input wire logic bitClockOut, // Internal bit clock
   input wire logic txWordTaken, // Word latch pulse
   input wire logic keeperOn // Keeper enable
);
   default clocking cb @(posedge refClk);
   endclocking
   default disable iff (srst);
   logic [7:0] drive_reg;
   logic [7:0] drive_next;
   logic unmapped;
   // -----------------------------------------------------------
   // Shadow of the drive register
   // -----------------------------------------------------------
   assign unmapped = !(paddr[9:2] inside {8'h00, 8'h1a, 8'h1b, 8'h1c, [8'h30:8'h33]});
   always_comb begin
      drive_next = drive_reg;
      if (psel && penable && pready && pwrite && !pslverr && paddr == 12'h06c) begin
         drive_next = pwdata[7:0];
      end
   end
   always_ff @(posedge refClk) begin
      drive_reg <= srst ? 8'h00 : drive_next;
   end
   // -----------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------
   sequence setupSeq;
      psel && !penable;
   endsequence
   sequence bclkHold;
      ($stable(bitClockOut) || !drive_reg[1]) [*3];
   endsequence
   chk_ready_follows: assert property (setupSeq |=> pready)
      else $error("ready missing after setup");
   chk_ready_single: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_err_qualified: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error without ready or with data");
   chk_misalign_err: assert property (setupSeq ##0 (paddr[1:0] != 2'h0) |=> pslverr)
      else $error("misaligned access accepted");
   chk_unmapped_err: assert property (setupSeq ##0 unmapped |=> pslverr)
      else $error("unmapped access accepted");
   chk_page_reach: assert property (setupSeq ##0 (paddr == 12'h000) |=> !pslverr)
      else $error("page register refused");
   chk_taken_pulse: assert property (txWordTaken |=> !txWordTaken)
      else $error("latch pulse too long");
   chk_keeper_off: assert property ((drive_reg[4:3] == 2'h0) [*3] |-> !keeperOn)
      else $error("keeper on in off mode");
   chk_int_bclk: assert property (drive_reg[1] && $changed(bitClockOut) |=>
      bclkHold ##1 ($changed(bitClockOut) || !drive_reg[1]))
      else $error("internal bit clock rate wrong");
endmodule : spt_tx_monitor
bind spt_tx_port spt_tx_monitor #(.INT_BCLK_HALF(INT_BCLK_HALF)) spt_tx_monitor_i (
   .refClk(refClk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .bitClockOut(bitClockOut), .txWordTaken(txWordTaken), .keeperOn(keeperOn));

//--- verification/spt_host_model.sv
// Host audio port model: makes bit clock and TDM frame sync, samples data pins.
// Assumes data launches on falling bit clock; samples at each falling edge.
`timescale 1ns/100ps
module spt_host_model (
   input wire logic run, // Keep making frames
   input var int frameLen, // Bit clocks per frame
   input wire logic [1:0] dataOut, // Device data pins
   input wire logic [1:0] dataOe, // Device pin enables
   output logic bitClock, // Bit clock to device
   output logic frameSync, // Frame sync to device
   output logic [63:0] capData [2], // Samples per pin
   output logic [63:0] capOe [2], // Enables per pin
   output int frameCount // Frames done
);
   // Frame generator, clock stands still between frames
   initial begin
      bitClock = 1'b0;
      frameSync = 1'b0;
      frameCount = 0;
      #37;
      forever begin
         if (run !== 1'b1) begin
            @(posedge run);
            #7; // Keep pin edges off the system clock edges
         end
         frameSync = 1'b1; // one bit clock high pulse
         for (int i = 0; i < frameLen; i++) begin
            #100 bitClock = 1'b1;
            #100 bitClock = 1'b0;
            frameSync = 1'b0;
            for (int p = 0; p < 2; p++) begin
               capData[p][i] = dataOut[p];
               capOe[p][i] = dataOe[p];
            end
         end
         frameCount++;
         #30;
      end
   end
endmodule : spt_host_model

//--- verification/test_spt_tx_port.sv
// Self-checking bench for spt_tx_port: APB master plus host port model.
// Assumes the monitor and host model are compiled before this file.
`timescale 1ns/100ps
module test_spt_tx_port;
   logic refClk, pready, pslverr, bitClockOut, frameSyncOut, txWordTaken, keeperOn, irq;
   logic srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
   logic bclk, fsync, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [31:0] txWord [2] = '{32'hc35a0f81, 32'h5ac3f018};
   logic [1:0] dataOut, dataOe;
   logic [63:0] capData [2];
   logic [63:0] capOe [2];
   int frameLen = 64, frameCount, err_total = 0, num_checks = 0;
   // -----------------------------------------------------------
   // Clock, design and host port
   // -----------------------------------------------------------
   initial begin
      refClk = 1'b0;
      forever #12.5 refClk = ~refClk;
   end
   spt_tx_port #(.NUM_PINS(2), .INT_BCLK_HALF(4)) spt_tx_port_i (.refClk(refClk),
      .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bitClockIn(bclk), .frameSyncIn(fsync), .bitClockOut(bitClockOut),
      .frameSyncOut(frameSyncOut), .txWord(txWord), .txWordTaken(txWordTaken),
      .dataOut(dataOut), .dataOe(dataOe), .keeperOn(keeperOn), .irq(irq));
   spt_host_model spt_host_model_i (.run(run), .frameLen(frameLen), .dataOut(dataOut),
      .dataOe(dataOe), .bitClock(bclk), .frameSync(fsync), .capData(capData),
      .capOe(capOe), .frameCount(frameCount));
   // -----------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic stall(input int n, input int lim);
      if (n >= lim) begin
         err_total++;
         conclude();
      end
   endtask : stall
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge refClk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge refClk);
      penable <= 1'b1;
      do begin
         @(posedge refClk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      stall(n, 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
      chk({31'h0, err}, {31'h0, e});
   endtask : rdchk
   task automatic frames(input int len, input int cnt);
      int n, f, tk;
      n = 0;
      tk = 0;
      f = frameCount;
      frameLen = len;
      run <= 1'b1;
      while (frameCount < f + cnt && n < 9000) begin
         @(posedge refClk);
         tk += txWordTaken;
         n++;
      end
      run <= 1'b0;
      stall(n, 9000);
      chk(tk, cnt);
      repeat (4) @(posedge refClk);
   endtask : frames
   task automatic cfg_run(input logic [7:0] fmt, input logic [7:0] drv, input int off);
      int wl;
      logic ed, eo;
      wl = fmt[5] ? 32 : 16;
      apb(1'b1, 12'h068, {24'h0, fmt});
      apb(1'b1, 12'h06c, {24'h0, drv});
      apb(1'b1, 12'h070, off);
      frames(64, 3);
      for (int p = 0; p < 2; p++) begin
         for (int j = 1; j < 64; j++) begin
            ed = 1'b0;
            eo = !drv[6];
            if (j > off && j <= off + wl) begin
               ed = txWord[p][wl - j + off];
               eo = !(drv[5] && j == off + wl);
            end
            chk({31'h0, capOe[p][j]}, {31'h0, eo});
            if (eo) chk({31'h0, capData[p][j]}, {31'h0, ed});
         end
      end
      if (drv[4:3] == 2'h1) chk({31'h0, keeperOn}, 32'h1);
      if (drv[4:3] == 2'h0) chk({31'h0, keeperOn}, 32'h0);
   endtask : cfg_run
   task automatic irqchk(input logic exp);
      repeat (3) @(posedge refClk);
      chk({31'h0, irq}, {31'h0, exp});
   endtask : irqchk
   // -----------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------
   initial begin
      int cnt, hi;
      logic last;
      cnt = 0;
      hi = 0;
      repeat (8) @(posedge refClk);
      srst <= 1'b0;
      rdchk(12'h000, 32'h00, 1'b0);
      rdchk(12'h068, 32'h30, 1'b0);
      rdchk(12'h06c, 32'h00, 1'b0);
      rdchk(12'h070, 32'h00, 1'b0);
      apb(1'b1, 12'h000, 32'hff);
      rdchk(12'h000, 32'hff, 1'b0);
      apb(1'b1, 12'h068, 32'h00);
      rdchk(12'h068, 32'h00, 1'b1);
      apb(1'b1, 12'h000, 32'h00);
      rdchk(12'h068, 32'h30, 1'b0);
      rdchk(12'h040, 32'h00, 1'b1);
      rdchk(12'h069, 32'h00, 1'b1);
      apb(1'b1, 12'h070, 32'hff);
      rdchk(12'h070, 32'h1f, 1'b0);
      $display("test registers done");
      cfg_run(8'h30, 8'h00, 0);
      cfg_run(8'h30, 8'h08, 3);
      cfg_run(8'h00, 8'h40, 0);
      cfg_run(8'h30, 8'h20, 5);
      cfg_run(8'h30, 8'h80, 2);
      $display("test frames done");
      apb(1'b1, 12'h070, 32'h0);
      apb(1'b1, 12'h06c, 32'h02);
      repeat (8) @(posedge refClk);
      last = bitClockOut;
      repeat (512) begin
         @(posedge refClk);
         cnt += (bitClockOut !== last);
         hi += frameSyncOut;
         last = bitClockOut;
      end
      chk(cnt, 128);
      chk(hi, 8);
      apb(1'b1, 12'h06c, 32'h00);
      $display("test internal clock done");
      apb(1'b1, 12'h0c8, 32'h1);
      frames(16, 3);
      irqchk(1'b1);
      apb(1'b1, 12'h0c8, 32'h0);
      irqchk(1'b0);
      apb(1'b1, 12'h0c8, 32'h1);
      irqchk(1'b1);
      apb(1'b1, 12'h0c4, 32'h3);
      irqchk(1'b0);
      rdchk(12'h0c0, 32'h0, 1'b0);
      frames(64, 3);
      rdchk(12'h0cc, 32'h1, 1'b0);
      apb(1'b1, 12'h068, 32'h32);
      apb(1'b1, 12'h0c4, 32'h3);
      frames(16, 3);
      irqchk(1'b0);
      apb(1'b1, 12'h068, 32'h31);
      frames(16, 3);
      rdchk(12'h0cc, 32'h3, 1'b0);
      frames(64, 2);
      rdchk(12'h0cc, 32'h3, 1'b0);
      apb(1'b1, 12'h068, 32'h30);
      frames(64, 2);
      rdchk(12'h0cc, 32'h1, 1'b0);
      $display("test bus error done");
      conclude();
   end
endmodule : test_spt_tx_port
